// File: inc/dcd_pkg.sv
/*
 * constants and types for the four-channel dma control decoder:
 * register offsets, control field positions, encodings and widths.
 * assumes a single 32-bit ahb-lite slave on core_clk_i.
 */
package dcd_pkg;
    localparam int NUM_CH = 4;
    localparam int ADDR_W = 32;

    // channel_control n at byte n*4; address pointers after them
    localparam logic [7:0] CTRL_BASE = 8'h00;
    localparam logic [7:0] SRC3_OFS = 8'h10;
    localparam logic [7:0] DST_OFS = 8'h14;
    localparam logic [7:0] STEP_OFS = 8'h18;
    localparam logic [7:0] STAT_OFS = 8'h1c;
    localparam logic [7:0] DATA_OFS = 8'h20;

    localparam int F_DI = 20;
    localparam int F_RO = 19;
    localparam int F_RL = 18;
    localparam int F_AM = 17;
    localparam int F_AL = 16;
    localparam int F_DM = 14;
    localparam int F_SM = 12;
    localparam int F_RS = 8;
    localparam int F_TS = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // writable bits of bits 20..8 and 6..0 (bits 31..21 and 7 reserved)
    localparam logic [31:0] CTRL_WMASK = 32'h001f_ff7f;

    localparam logic [1:0] STEP_FIXED = 2'h0;
    localparam logic [1:0] STEP_INC = 2'h1;
    localparam logic [1:0] STEP_DEC = 2'h2;

    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;
    localparam logic [1:0] SIZE_16B = 2'h3;

    localparam logic [3:0] RS_EXT_DUAL = 4'h0;
    localparam logic [3:0] RS_EXT_MEM2DEV = 4'h2;
    localparam logic [3:0] RS_EXT_DEV2MEM = 4'h3;
    localparam logic [3:0] RS_AUTO = 4'h4;
    localparam logic [3:0] RS_EXPANSION = 4'h8;
    localparam logic [3:0] RS_SPA_TX = 4'ha;
    localparam logic [3:0] RS_SPA_RX = 4'hb;
    localparam logic [3:0] RS_SPB_TX = 4'hc;
    localparam logic [3:0] RS_SPB_RX = 4'hd;
    localparam logic [3:0] RS_CONV = 4'he;
    localparam logic [3:0] RS_TIMER = 4'hf;

    localparam logic [ADDR_W-1:0] INDIRECT_STEP = 32'h0000_0004;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        DCD_XFER_SINGLE,
        DCD_XFER_DUAL_READ,
        DCD_XFER_DUAL_WRITE
    } dcd_phase_t;
endpackage

// File: inc/dcd_stream_if.sv
/*
 * valid/ready word stream between the decoder core and its fifo.
 * assumes both ends share one clock.
 */
interface dcd_stream_if #(parameter int WIDTH = 32);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// File: hdl/dcd_fifo.sv
/*
 * synchronous fifo with parameter width and depth, valid/ready both sides.
 * assumes depth is a power of two and a single clock.
 */
module dcd_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    dcd_stream_if.dst in_if,
    dcd_stream_if.src out_if,
    output logic full_o,
    output logic empty_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ff, rd_ff;
    logic [AW:0] nxt_wr, nxt_rd;
    logic push, pop;

    assign full_o = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
    assign empty_o = (wr_ff == rd_ff);
    assign in_if.ready = !full_o;
    assign out_if.valid = !empty_o;
    assign out_if.data = mem_ff[rd_ff[AW-1:0]];
    assign push = in_if.valid && !full_o;
    assign pop = out_if.ready && !empty_o;

    always_comb begin
        nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
        end
    end

    // storage carries no reset; contents are only read once written
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_ff[wr_ff[AW-1:0]] <= in_if.data;
        end
    end
endmodule

// File: hdl/dcd_chan_step.sv
/*
 * per-channel address step and request-source qualification.
 * assumes control fields come straight from the channel's control register.
 */
module dcd_chan_step #(
    parameter int CHAN = 0
) (
    input wire logic [31:0] ctrl_i,
    input wire logic [3:0] req_pins_i,
    input wire logic [5:0] periph_req_i,
    input wire logic expansion_req_i,
    output logic [31:0] dst_step_o,
    output logic [31:0] src_step_o,
    output logic legal_o,
    output logic req_o,
    output logic single_addr_o
);
    logic [1:0] size, dm, sm;
    logic [3:0] rs;
    logic indirect;
    logic [31:0] unit;
    logic ext_ok;

    always_comb begin
        size = ctrl_i[dcd_pkg::F_TS +: 2];
        dm = ctrl_i[dcd_pkg::F_DM +: 2];
        sm = ctrl_i[dcd_pkg::F_SM +: 2];
        rs = ctrl_i[dcd_pkg::F_RS +: 4];
        indirect = ctrl_i[dcd_pkg::F_DI];
        ext_ok = (CHAN < 2);
        unit = 32'h0000_0001 << size;
        if (size == dcd_pkg::SIZE_16B) begin
            unit = 32'h0000_0010;
        end
        legal_o = 1'b1;
        if (dm == 2'h3 || sm == 2'h3) begin
            legal_o = 1'b0;
        end
        if (size == dcd_pkg::SIZE_16B && (dm == dcd_pkg::STEP_DEC || sm == dcd_pkg::STEP_DEC)) begin
            legal_o = 1'b0;
        end
        unique case (dm)
            dcd_pkg::STEP_INC: dst_step_o = unit;
            dcd_pkg::STEP_DEC: dst_step_o = -unit;
            default: dst_step_o = '0;
        endcase
        unique case (sm)
            dcd_pkg::STEP_INC: src_step_o = indirect ? dcd_pkg::INDIRECT_STEP : unit;
            dcd_pkg::STEP_DEC: src_step_o = indirect ? -dcd_pkg::INDIRECT_STEP : -unit;
            default: src_step_o = '0;
        endcase
        single_addr_o = 1'b0;
        req_o = 1'b0;
        unique case (rs)
            dcd_pkg::RS_EXT_DUAL: req_o = ext_ok && req_pins_i[CHAN];
            dcd_pkg::RS_EXT_MEM2DEV, dcd_pkg::RS_EXT_DEV2MEM: begin
                req_o = ext_ok && req_pins_i[CHAN];
                single_addr_o = ext_ok;
            end
            dcd_pkg::RS_AUTO: req_o = 1'b1;
            dcd_pkg::RS_EXPANSION: req_o = expansion_req_i;
            dcd_pkg::RS_SPA_TX: req_o = periph_req_i[0];
            dcd_pkg::RS_SPA_RX: req_o = periph_req_i[1];
            dcd_pkg::RS_SPB_TX: req_o = periph_req_i[2];
            dcd_pkg::RS_SPB_RX: req_o = periph_req_i[3];
            dcd_pkg::RS_CONV: req_o = periph_req_i[4];
            dcd_pkg::RS_TIMER: req_o = periph_req_i[5];
            default: legal_o = 1'b0;
        endcase
        if (!legal_o) begin
            req_o = 1'b0;
            dst_step_o = '0;
            src_step_o = '0;
        end
    end
endmodule

// File: hdl/dcd_ctrl_decode.sv
/*
 * four-channel dma control register decode: ahb-lite slave holding the
 * channel control registers, a destination pointer stepped once in each cycle
 * with a granted request and fifo room, a source pointer stepped only on channel 2 or 3 grants, acknowledge pin polarity, and a fifo of the source pointer
 * value at each granted step, taken before it moves, for the transfer engine downstream.
 * assumes one ahb-lite master, word transfers, and request pins from
 * outside the clock domain.
 */
// The AHB-Lite interface to the registers and the register offsets were decided locally.
module dcd_ctrl_decode #(
    parameter int FIFO_DEPTH = dcd_pkg::FIFO_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [3:0] transfer_request_in_i,
    input wire logic [5:0] periph_req_i,
    input wire logic [3:0] expansion_req_i,
    input wire logic [3:0] grant_i,
    input wire logic [1:0] xfer_phase_i,
    output logic [1:0] request_acknowledge_out_o,
    output logic [1:0] transfer_acknowledge_out_o,
    output logic [3:0] chan_req_o,
    output logic [3:0] single_addr_o,
    output logic [31:0] src_addr_o,
    output logic src_valid_o,
    input wire logic src_ready_i
);
    logic [31:0] ctrl_ff [dcd_pkg::NUM_CH];
    logic [31:0] nxt_ctrl [dcd_pkg::NUM_CH];
    logic [31:0] src3_ff, nxt_src3, dst_ff, nxt_dst, src3_init_ff, nxt_src3_init;
    logic [3:0] req_meta_ff, req_sync_ff;
    logic [31:0] dst_step [dcd_pkg::NUM_CH];
    logic [31:0] src_step [dcd_pkg::NUM_CH];
    logic [3:0] legal, req;
    logic wr_pend_ff, nxt_wr_pend, nxt_rd_pend;
    logic [7:0] addr_ff, nxt_addr;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [3:0] hit;
    logic [1:0] request_acknowledge_out_ff, nxt_request_acknowledge_out, transfer_acknowledge_out_ff, nxt_transfer_acknowledge_out;
    logic fifo_full, fifo_empty;
    logic [1:0] sel;

    dcd_stream_if #(.WIDTH(32)) push_if ();
    dcd_stream_if #(.WIDTH(32)) pop_if ();

    // the fifo's readiness gates grants: a granted step without room is dropped
    assign hit = grant_i & req & {4{push_if.ready}};
    assign push_if.valid = |hit;
    assign push_if.data = src3_ff;
    assign src_addr_o = pop_if.data;
    assign src_valid_o = pop_if.valid;
    assign pop_if.ready = src_ready_i;

    dcd_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .in_if(push_if),
        .out_if(pop_if),
        .full_o(fifo_full),
        .empty_o(fifo_empty)
    );

    genvar g;
    generate
        for (g = 0; g < dcd_pkg::NUM_CH; g++) begin : g_ch
            dcd_chan_step #(.CHAN(g)) u_step (
                .ctrl_i(ctrl_ff[g]),
                .req_pins_i(req_sync_ff),
                .periph_req_i(periph_req_i),
                .expansion_req_i(expansion_req_i[g]),
                .dst_step_o(dst_step[g]),
                .src_step_o(src_step[g]),
                .legal_o(legal[g]),
                .req_o(req[g]),
                .single_addr_o(single_addr_o[g])
            );
        end
    endgenerate

    assign chan_req_o = req;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = rdata_ff;
    assign request_acknowledge_out_o = request_acknowledge_out_ff;
    assign transfer_acknowledge_out_o = transfer_acknowledge_out_ff;
    assign sel = hit[3] ? 2'h3 : hit[2] ? 2'h2 : hit[1] ? 2'h1 : 2'h0;

    always_comb begin
        nxt_wr_pend = 1'b0;
        nxt_rd_pend = 1'b0;
        nxt_addr = addr_ff;
        if (hsel_i && hready_i && htrans_i[1]) begin
            nxt_wr_pend = hwrite_i;
            nxt_rd_pend = !hwrite_i;
            nxt_addr = haddr_i[7:0];
        end
    end

    always_comb begin
        for (int i = 0; i < dcd_pkg::NUM_CH; i++) begin
            nxt_ctrl[i] = ctrl_ff[i];
            if (wr_pend_ff && addr_ff == dcd_pkg::CTRL_BASE + 8'(i * 4)) begin
                nxt_ctrl[i] = hwdata_i & dcd_pkg::CTRL_WMASK;
                if (i != 3) nxt_ctrl[i][dcd_pkg::F_DI] = 1'b0;
                if (i != 2) nxt_ctrl[i][dcd_pkg::F_RO] = 1'b0;
                if (i >= 2) begin
                    nxt_ctrl[i][dcd_pkg::F_RL] = 1'b0;
                    nxt_ctrl[i][dcd_pkg::F_AM] = 1'b0;
                    nxt_ctrl[i][dcd_pkg::F_AL] = 1'b0;
                    nxt_ctrl[i][6] = 1'b0;
                end
            end
        end
        nxt_src3 = src3_ff;
        nxt_src3_init = src3_init_ff;
        nxt_dst = dst_ff;
        if (push_if.valid) begin
            nxt_dst = dst_ff + dst_step[sel];
            if (hit[3] || hit[2]) begin
                nxt_src3 = src3_ff + src_step[sel];
            end
            // reload: pointer returns to its initial value each channel 2 step
            if (hit[2] && ctrl_ff[2][dcd_pkg::F_RO]) nxt_src3 = src3_init_ff;
        end
        if (wr_pend_ff && addr_ff == dcd_pkg::SRC3_OFS) begin
            nxt_src3 = hwdata_i;
            nxt_src3_init = hwdata_i;
        end
        if (wr_pend_ff && addr_ff == dcd_pkg::DST_OFS) nxt_dst = hwdata_i;
    end

    always_comb begin
        nxt_rdata = rdata_ff;
        if (nxt_rd_pend) begin
            unique case (haddr_i[7:0])
                8'h00, 8'h04, 8'h08, 8'h0c: nxt_rdata = ctrl_ff[haddr_i[3:2]];
                dcd_pkg::SRC3_OFS: nxt_rdata = src3_ff;
                dcd_pkg::DST_OFS: nxt_rdata = dst_ff;
                dcd_pkg::STEP_OFS: nxt_rdata = src_step[3];
                dcd_pkg::STAT_OFS: nxt_rdata = {22'h0, fifo_empty, fifo_full, req, legal};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            // asserted level is the polarity bit itself: clear means active low
            nxt_request_acknowledge_out[i] = ~(req[i] ^ ctrl_ff[i][dcd_pkg::F_RL]);
            nxt_transfer_acknowledge_out[i] = ~ctrl_ff[i][dcd_pkg::F_AL];
            if (hit[i]) begin
                if (single_addr_o[i]
                    || (xfer_phase_i == dcd_pkg::DCD_XFER_DUAL_WRITE && ctrl_ff[i][dcd_pkg::F_AM])
                    || (xfer_phase_i == dcd_pkg::DCD_XFER_DUAL_READ && !ctrl_ff[i][dcd_pkg::F_AM])) begin
                    nxt_transfer_acknowledge_out[i] = ctrl_ff[i][dcd_pkg::F_AL];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < dcd_pkg::NUM_CH; i++) ctrl_ff[i] <= dcd_pkg::CTRL_RESET;
            src3_ff <= '0;
            src3_init_ff <= '0;
            dst_ff <= '0;
            req_meta_ff <= '0;
            req_sync_ff <= '0;
            wr_pend_ff <= 1'b0;
            addr_ff <= '0;
            rdata_ff <= '0;
            request_acknowledge_out_ff <= 2'h3;
            transfer_acknowledge_out_ff <= 2'h3;
        end else begin
            ctrl_ff <= nxt_ctrl;
            src3_ff <= nxt_src3;
            src3_init_ff <= nxt_src3_init;
            dst_ff <= nxt_dst;
            req_meta_ff <= ~transfer_request_in_i;
            req_sync_ff <= req_meta_ff;
            wr_pend_ff <= nxt_wr_pend;
            addr_ff <= nxt_addr;
            rdata_ff <= nxt_rdata;
            request_acknowledge_out_ff <= nxt_request_acknowledge_out;
            transfer_acknowledge_out_ff <= nxt_transfer_acknowledge_out;
        end
    end
endmodule

// File: bench/dcd_req_partner.sv
/*
 * far side of the decoder: external requesters and on-chip modules.
 * assumes the bench says which sources want service each cycle.
 */
module dcd_req_partner (
    input wire logic core_clk_i,
    input wire logic [3:0] want_i,
    input wire logic [5:0] pwant_i,
    output logic [3:0] pins_o,
    output logic [5:0] periph_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pins_o = 4'hf;
        periph_o = 6'h00;
    end
    // request pins are active low; module requests are active high
    always @(posedge core_clk_i) begin
        pins_o <= ~want_i;
        periph_o <= pwant_i;
    end
endmodule

// File: bench/dcd_ctrl_decode_asserts.sv
/*
 * checker for the control decoder, bound to its top module.
 * assumes ahb-lite word reads answered one cycle after the address phase.
 */
module dcd_ctrl_decode_asserts (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic [3:0] grant_i,
    input wire logic [3:0] chan_req_o,
    input wire logic [3:0] single_addr_o,
    input wire logic [1:0] request_acknowledge_out_o,
    input wire logic [1:0] transfer_acknowledge_out_o,
    input wire logic [31:0] src_addr_o,
    input wire logic src_valid_o,
    input wire logic src_ready_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    wire rd_ctl = hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[7:4] == 4'h0;
    wire [1:0] ch = haddr_i[3:2];
    property p_rsvd; rd_ctl |=> (hrdata_o & 32'hffe0_0080) == 32'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved control bits read nonzero");
    property p_ind_only3; rd_ctl && ch != 2'h3 |=> !hrdata_o[20]; endproperty
    a_ind_only3: assert property (p_ind_only3) else $error("indirect select outside channel 3");
    property p_reload_only2; rd_ctl && ch != 2'h2 |=> !hrdata_o[19]; endproperty
    a_reload_only2: assert property (p_reload_only2) else $error("reload bit outside channel 2");
    property p_pol_only01; rd_ctl && ch[1] |=> hrdata_o[18:16] == 3'h0; endproperty
    a_pol_only01: assert property (p_pol_only01) else $error("ack bits in channel 2 or 3");
    property p_no_ext_hi; single_addr_o[3:2] == 2'h0; endproperty
    a_no_ext_hi: assert property (p_no_ext_hi) else $error("single address mode in channel 2 or 3");
    property p_ack_rst; !$past(resetn_i) |-> transfer_acknowledge_out_o == 2'h3 && request_acknowledge_out_o == 2'h3;
    endproperty
    a_ack_rst: assert property (p_ack_rst) else $error("acknowledge not inactive after reset");
    property p_push_cause; $rose(src_valid_o) |-> $past(|(grant_i & chan_req_o)); endproperty
    a_push_cause: assert property (p_push_cause) else $error("fifo push without a granted request");
    property p_head_hold; src_valid_o && !src_ready_i |=> src_valid_o && $stable(src_addr_o); endproperty
    a_head_hold: assert property (p_head_hold) else $error("fifo head changed while stalled");
    property p_okay; hreadyout_o && !hresp_o; endproperty
    a_okay: assert property (p_okay) else $error("bus not ready or not okay");
endmodule

bind dcd_ctrl_decode dcd_ctrl_decode_asserts u_chk (.core_clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .grant_i, .chan_req_o, .single_addr_o,
    .request_acknowledge_out_o, .transfer_acknowledge_out_o, .src_addr_o, .src_valid_o, .src_ready_i);

// File: bench/test_dma_channel_control_decode.sv
/*
 * self-checking bench for the control decoder with a requester model.
 * assumes the bus answers with hreadyout_o and reads land one edge later.
 */
module test_dma_channel_control_decode;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic hsel_i = 1'b0, hwrite_i = 1'b0, src_ready_i = 1'b0, rd_dp = 1'b0, stall = 1'b0;
    logic [1:0] htrans_i = 2'h0, xfer_phase_i = 2'h0, request_acknowledge_out_o, transfer_acknowledge_out_o;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, src_addr_o, dst, src, src0, v;
    logic [3:0] grant_i = 4'h0, want = 4'h0, expansion_req_i = 4'h0, transfer_request_in_i, chan_req_o, single_addr_o;
    logic [5:0] pwant = 6'h00, periph_req_i;
    logic hreadyout_o, hresp_o, src_valid_o;
    wire hready_i = hreadyout_o;
    logic [31:0] rd_q[$], src_q[$];
    int bad_count = 0;
    int n_compared = 0;
    int st;
    always #20 core_clk_i = ~core_clk_i;
    dcd_ctrl_decode dut (.core_clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
        .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .transfer_request_in_i, .periph_req_i, .expansion_req_i,
        .grant_i, .xfer_phase_i, .request_acknowledge_out_o, .transfer_acknowledge_out_o, .chan_req_o,
        .single_addr_o, .src_addr_o, .src_valid_o, .src_ready_i);
    dcd_req_partner u_far (.core_clk_i, .want_i(want), .pwant_i(pwant), .pins_o(transfer_request_in_i),
        .periph_o(periph_req_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= w;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        rd_dp <= !w;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        rd_dp <= 1'b0;
        hsel_i <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic gnt(input logic [3:0] g);
        @(posedge core_clk_i);
        grant_i <= g;
        @(posedge core_clk_i);
        grant_i <= 4'h0;
    endtask
    function automatic logic [31:0] mask(input int c);
        logic [31:0] m;
        m = dcd_pkg::CTRL_WMASK;
        m[20] = (c == 3);
        m[19] = (c == 2);
        if (c > 1) begin
            m[18:16] = 3'h0;
            m[6] = 1'b0;
        end
        return m;
    endfunction
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        src_ready_i <= stall ? 1'b0 : 1'($urandom() % 2);
        if (rd_dp && hreadyout_o) chk(hrdata_o, rd_q.pop_front());
        if (src_valid_o && src_ready_i) chk(src_addr_o, src_q.pop_front());
    end
    initial begin
        #(40 * 30000);
        bad_count++;
        results();
    end
    initial begin
        void'($urandom(90604));
        repeat (6) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            rd(32'(4 * c), 32'h0);
            for (int k = 0; k < 2; k++) begin
                v = k ? 32'hffff_ffff : $urandom();
                xfer(1'b1, 32'(4 * c), v);
                rd(32'(4 * c), v & mask(c));
            end
        end
        xfer(1'b1, 32'h24, v);
        rd(32'h24, 32'h0);
        for (int c = 1; c < 4; c++) xfer(1'b1, 32'(4 * c), 32'h0);
        // every request source code, legal or not, in an external-capable and an internal-only channel
        want <= 4'hf;
        pwant <= 6'h3f;
        expansion_req_i <= 4'hf;
        for (int r = 0; r < 16; r++) begin
            xfer(1'b1, 32'h0, 32'(r) << 8);
            xfer(1'b1, 32'h8, 32'(r) << 8);
            repeat (3) @(negedge core_clk_i);
            st = (r == 4 || r == 8 || r >= 10);
            chk(chan_req_o[0], st || r == 0 || r == 2 || r == 3);
            chk(chan_req_o[2], st);
            chk(single_addr_o[0], r == 2 || r == 3);
        end
        pwant <= 6'h00;
        repeat (3) @(negedge core_clk_i);
        chk(chan_req_o[2], 1'b0);
        // step table: every size against increment, decrement and the illegal code
        dst = $urandom();
        src = $urandom();
        src0 = src;
        xfer(1'b1, 32'h14, dst);
        xfer(1'b1, 32'h10, src);
        for (int s = 0; s < 4; s++) begin
            for (int m = 1; m < 4; m++) begin
                xfer(1'b1, 32'h0, (32'h4 << 8) | (32'(m) << 14) | (32'(m) << 12) | (32'(s) << 3));
                gnt(4'h1);
                if (m == 1 || (m == 2 && s != 3)) begin
                    src_q.push_back(src);
                    st = (s == 3) ? 16 : (1 << s);
                    dst = (m == 1) ? dst + 32'(st) : dst - 32'(st);
                end
                rd(32'h14, dst);
            end
        end
        // channel 3 source stepping: indirect inc, indirect dec, direct word inc
        for (int k = 0; k < 3; k++) begin
            xfer(1'b1, 32'hc, (32'h4 << 8) | (k < 2 ? 32'h10_0000 : 32'h0) | (32'(k == 1 ? 2 : 1) << 12) | 32'h8);
            gnt(4'h8);
            src_q.push_back(src);
            src = (k == 0) ? src + 32'h4 : (k == 1) ? src - 32'h4 : src + 32'h2;
            rd(32'h10, src);
        end
        rd(32'h18, 32'h2);
        // a channel 3 step moves the pointer, a reloading channel 2 step brings it back
        xfer(1'b1, 32'h8, (32'h4 << 8) | 32'h8_0000 | (32'h1 << 12));
        gnt(4'h8);
        src_q.push_back(src);
        gnt(4'h4);
        src_q.push_back(src + 32'h2);
        src = src0;
        rd(32'h10, src);
        // transfer acknowledge level and cycle for both polarities and modes in the dual read and dual write phases; request acknowledge at one polarity
        want <= 4'h1;
        repeat (4) @(posedge core_clk_i);
        for (int k = 0; k < 8; k++) begin
            xfer(1'b1, 32'h0, 32'h4_0000 | (32'(k[1:0]) << 16));
            xfer_phase_i <= k[2] ? 2'h2 : 2'h1;
            gnt(4'h1);
            src_q.push_back(src);
            #1;
            chk(transfer_acknowledge_out_o[0], (k[1] == k[2]) ? k[0] : !k[0]);
            chk(request_acknowledge_out_o[0], 1'b1);
        end
        // fill the fifo with the reader stalled: only eight grants take effect
        want <= 4'h0;
        for (int i = 0; i < 200 && src_valid_o; i++) @(posedge core_clk_i);
        stall <= 1'b1;
        xfer(1'b1, 32'h0, (32'h4 << 8) | (32'h1 << 14));
        for (int i = 0; i < 10; i++) gnt(4'h1);
        for (int i = 0; i < dcd_pkg::FIFO_DEPTH; i++) src_q.push_back(src);
        rd(32'h14, dst + 32'(dcd_pkg::FIFO_DEPTH));
        rd(32'h1c, 32'h0000_01df);
        stall <= 1'b0;
        for (int i = 0; i < 200 && src_valid_o !== 1'b0; i++) @(posedge core_clk_i);
        chk(32'(src_q.size()), 32'h0);
        results();
    end
endmodule
